/* File: rtl/incdec_jump_pkg.sv */
// constants, encodings and types shared by the inc/dec, skip, jump and or-immediate logic
`default_nettype none

package incdec_jump_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int INSTR_W   = 12;
    localparam int DATA_W    = 8;
    localparam int PC_W      = 11;
    localparam int FADDR_W   = 5;
    localparam int JUMP_K_W  = 9;
    localparam int ORIMM_W   = 8;
    localparam int PAGE_W    = 2;

    // ****************************************
    // field positions in the instruction word and the status byte
    // ****************************************
    localparam int FADDR_LSB       = 0;
    localparam int DEST_BIT        = 5;
    localparam int FILEOP_LSB      = 6;
    localparam int JUMPOP_LSB      = 9;
    localparam int ORIMMOP_LSB     = 8;
    localparam int STATUS_PAGE_LSB = 5;

    // ****************************************
    // opcode patterns (upper bits of the word)
    // ****************************************
    localparam logic [5:0] OPC_DECREMENT_REGISTER      = 6'h03;
    localparam logic [5:0] OPC_DECREMENT_SKIP_ON_ZERO  = 6'h0B;
    localparam logic [5:0] OPC_INCREMENT_REGISTER      = 6'h0A;
    localparam logic [5:0] OPC_INCREMENT_SKIP_ON_ZERO  = 6'h0F;
    localparam logic [2:0] OPC_ABSOLUTE_JUMP           = 3'h5;
    localparam logic [3:0] OPC_OR_IMMEDIATE            = 4'hD;

    // ****************************************
    // reset values and arithmetic constants
    // ****************************************
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [PC_W-1:0]   PC_RESET   = 11'h000;
    localparam logic [DATA_W-1:0] DATA_ONE   = 8'h01;
    localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        OP_NONE     = 3'b000,
        OP_DEC      = 3'b001,
        OP_DEC_SKIP = 3'b010,
        OP_INC      = 3'b011,
        OP_INC_SKIP = 3'b100,
        OP_JUMP     = 3'b101,
        OP_OR_IMM   = 3'b110
    } op_type;

    typedef enum logic {
        ST_EXEC  = 1'b0,
        ST_FLUSH = 1'b1
    } state_type;

endpackage

`default_nettype wire

/* File: rtl/alu_if.sv */
// carrier between the executing core and its arithmetic unit
`default_nettype none

interface alu_if;
    import incdec_jump_pkg::*;

    op_type              op;
    logic [DATA_W-1:0]   operand;
    logic [DATA_W-1:0]   accum;
    logic [ORIMM_W-1:0]  imm;
    logic [DATA_W-1:0]   result;
    logic                isZero;

    modport core (output op, output operand, output accum, output imm,
                  input result, input isZero);
    modport unit (input op, input operand, input accum, input imm,
                  output result, output isZero);
endinterface

`default_nettype wire

/* File: rtl/incdec_or_unit.sv */
// combinational increment, decrement and or-immediate unit with zero detect
`default_nettype none

module incdec_or_unit
    import incdec_jump_pkg::*;
(
    alu_if.unit au
);

    // ****************************************
    // result select
    // ****************************************
    // 8-bit add and subtract wrap modulo 256
    always_comb begin
        unique case (au.op)
            OP_DEC, OP_DEC_SKIP: au.result = au.operand - DATA_ONE;
            OP_INC, OP_INC_SKIP: au.result = au.operand + DATA_ONE;
            OP_OR_IMM:           au.result = au.accum | au.imm;
            default:             au.result = DATA_ZERO;
        endcase
    end

    // zero detect on the full 8-bit result
    assign au.isZero = (au.result == DATA_ZERO);

endmodule

`default_nettype wire

/* File: rtl/incdec_skip_jump_exec.sv */
// execution of decrement/increment (with skip), absolute jump and or-immediate
// Overview of operation
// - decrement register, destination bit, update zero
// - decrement-and-skip stores result, flags untouched
// - zero result discards prefetched instruction, two cycles
// - jump loads nine-bit immediate into pc
// - jump copies status bits 6:5 to pc
// - jump takes two cycles, flags untouched
// - increment register, destination bit, update zero
// - increment-and-skip stores result, flags untouched
// - zero result discards prefetched instruction, two cycles
// - or immediate into accumulator, update zero
`default_nettype none

module incdec_skip_jump_exec
    import incdec_jump_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                reset_n,
    input  wire logic                instrValid,
    input  wire logic [INSTR_W-1:0]  instrWord,
    input  wire logic [DATA_W-1:0]   fileRdData,
    input  wire logic [DATA_W-1:0]   accIn,
    input  wire logic [DATA_W-1:0]   statusIn,
    output var  logic                accWrEn_q,
    output var  logic [DATA_W-1:0]   accWrData_q,
    output var  logic                fileWrEn_q,
    output var  logic [FADDR_W-1:0]  fileWrAddr_q,
    output var  logic [DATA_W-1:0]   fileWrData_q,
    output var  logic                zeroWrEn_q,
    output var  logic                zeroValue_q,
    output var  logic                pcLoad_q,
    output var  logic [PC_W-1:0]     pcTarget_q,
    output var  logic                discardFetch_q
);

    // ****************************************
    // decode
    // ****************************************
    state_type state_q;
    op_type    op;
    logic      take;
    logic      destFile;
    logic      skipOp;
    logic      fileOp;
    logic      doSkip;
    alu_if     au ();

    // an instruction is taken only outside the discarded slot
    assign take     = instrValid && (state_q == ST_EXEC);
    assign destFile = instrWord[DEST_BIT];

    // opcode match
    always_comb begin
        op = OP_NONE;
        if (take) begin
            if (instrWord[INSTR_W-1:FILEOP_LSB] == OPC_DECREMENT_REGISTER) begin
                op = OP_DEC;
            end else if (instrWord[INSTR_W-1:FILEOP_LSB] == OPC_DECREMENT_SKIP_ON_ZERO) begin
                op = OP_DEC_SKIP;
            end else if (instrWord[INSTR_W-1:FILEOP_LSB] == OPC_INCREMENT_REGISTER) begin
                op = OP_INC;
            end else if (instrWord[INSTR_W-1:FILEOP_LSB] == OPC_INCREMENT_SKIP_ON_ZERO) begin
                op = OP_INC_SKIP;
            end else if (instrWord[INSTR_W-1:JUMPOP_LSB] == OPC_ABSOLUTE_JUMP) begin
                op = OP_JUMP;
            end else if (instrWord[INSTR_W-1:ORIMMOP_LSB] == OPC_OR_IMMEDIATE) begin
                op = OP_OR_IMM;
            end
        end
    end

    assign skipOp = (op == OP_DEC_SKIP) || (op == OP_INC_SKIP);
    assign fileOp = skipOp || (op == OP_DEC) || (op == OP_INC);
    assign doSkip = skipOp && au.isZero;

    // ****************************************
    // arithmetic unit
    // ****************************************
    assign au.op      = op;
    assign au.operand = fileRdData;
    assign au.accum   = accIn;
    assign au.imm     = instrWord[ORIMM_W-1:0];

    incdec_or_unit alu_u (
        .au (au)
    );

    // ****************************************
    // discard slot state machine
    // ****************************************
    // a taken branch or skip turns the next fetched instruction into a no-op
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_EXEC;
        end else begin
            unique case (state_q)
                ST_EXEC:  state_q <= (doSkip || op == OP_JUMP) ? ST_FLUSH : ST_EXEC;
                ST_FLUSH: state_q <= ST_EXEC;
            endcase
        end
    end

    // discard marker shown during the no-op slot
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            discardFetch_q <= 1'b0;
        end else begin
            discardFetch_q <= doSkip || (op == OP_JUMP);
        end
    end

    // ****************************************
    // result write-back
    // ****************************************
    // destination bit chooses file register or accumulator
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fileWrEn_q   <= 1'b0;
            fileWrAddr_q <= '0;
            fileWrData_q <= DATA_RESET;
        end else begin
            fileWrEn_q   <= fileOp && destFile;
            fileWrAddr_q <= instrWord[FADDR_LSB +: FADDR_W];
            fileWrData_q <= au.result;
        end
    end

    // accumulator gets file results with destination 0 and or-immediate
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            accWrEn_q   <= 1'b0;
            accWrData_q <= DATA_RESET;
        end else begin
            accWrEn_q   <= (fileOp && !destFile) || (op == OP_OR_IMM);
            accWrData_q <= au.result;
        end
    end

    // ****************************************
    // zero flag
    // ****************************************
    // skip forms and the jump leave the flags alone
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            zeroWrEn_q  <= 1'b0;
            zeroValue_q <= 1'b0;
        end else begin
            zeroWrEn_q  <= (op == OP_DEC) || (op == OP_INC) || (op == OP_OR_IMM);
            zeroValue_q <= au.isZero;
        end
    end

    // ****************************************
    // program counter load
    // ****************************************
    // page bits from status above the nine-bit target
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pcLoad_q   <= 1'b0;
            pcTarget_q <= PC_RESET;
        end else begin
            pcLoad_q   <= (op == OP_JUMP);
            pcTarget_q <= {statusIn[STATUS_PAGE_LSB +: PAGE_W],
                           instrWord[JUMP_K_W-1:0]};
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_dec_result: assert property ((op == OP_DEC) |=>
        ($past(destFile) ? fileWrEn_q : accWrEn_q) && zeroWrEn_q &&
        ((fileWrEn_q ? fileWrData_q : accWrData_q) == $past(fileRdData) - DATA_ONE))
        else $error("decrement result or destination wrong");

    a_decskip_flags: assert property ((op == OP_DEC_SKIP) |=>
        !zeroWrEn_q && (fileWrEn_q != accWrEn_q) &&
        ((fileWrEn_q ? fileWrData_q : accWrData_q) == $past(fileRdData) - DATA_ONE))
        else $error("decrement-and-skip result or flags wrong");

    a_skip_zero: assert property ((skipOp && fileRdData == (op == OP_DEC_SKIP ? 8'h01 : 8'hFF))
        |=> discardFetch_q ##1 !discardFetch_q && !accWrEn_q && !fileWrEn_q)
        else $error("zero skip result did not discard one slot");

    a_skip_nonzero: assert property ((skipOp && !au.isZero) |=> !discardFetch_q)
        else $error("skip taken on nonzero result");

    a_jump_target: assert property ((op == OP_JUMP) |=> pcLoad_q &&
        pcTarget_q[JUMP_K_W-1:0] == $past(instrWord[JUMP_K_W-1:0]))
        else $error("jump target low bits wrong");

    a_jump_page: assert property ((op == OP_JUMP) |=>
        pcTarget_q[PC_W-1:JUMP_K_W] == $past(statusIn[STATUS_PAGE_LSB +: PAGE_W]))
        else $error("jump page bits wrong");

    a_jump_cycles: assert property ((op == OP_JUMP) |=>
        discardFetch_q && !zeroWrEn_q ##1 !pcLoad_q && !zeroWrEn_q)
        else $error("jump not two cycles or touched flags");

    a_inc_result: assert property ((op == OP_INC) |=> zeroWrEn_q &&
        ((fileWrEn_q ? fileWrData_q : accWrData_q) == $past(fileRdData) + DATA_ONE))
        else $error("increment result wrong");

    a_incskip_flags: assert property ((op == OP_INC_SKIP) |=> !zeroWrEn_q &&
        ((fileWrEn_q ? fileWrData_q : accWrData_q) == $past(fileRdData) + DATA_ONE))
        else $error("increment-and-skip result or flags wrong");

    a_or_result: assert property ((op == OP_OR_IMM) |=> accWrEn_q && !fileWrEn_q &&
        accWrData_q == ($past(accIn) | $past(instrWord[ORIMM_W-1:0])))
        else $error("or-immediate result wrong");

    a_zero_value: assert property (zeroWrEn_q |->
        zeroValue_q == ((accWrEn_q ? accWrData_q : fileWrData_q) == DATA_ZERO))
        else $error("zero flag does not follow result");

    c_dec_skip: cover property ((op == OP_DEC_SKIP) && au.isZero);
    c_inc_wrap: cover property ((op == OP_INC) && fileRdData == 8'hFF);
    c_jump:     cover property ((op == OP_JUMP) ##1 instrValid);
    c_or_imm:   cover property ((op == OP_OR_IMM) && au.isZero);

endmodule

`default_nettype wire

/* File: verification/core_model.sv */
// behavioural model of the register file, accumulator and status bits around the block
`default_nettype none

module core_model
    import incdec_jump_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               reset_n,
    input  wire logic [FADDR_W-1:0] rdAddr,
    input  wire logic [PAGE_W-1:0]  pageSel,
    input  wire logic               accWrEn,
    input  wire logic [DATA_W-1:0]  accWrData,
    input  wire logic               fileWrEn,
    input  wire logic [FADDR_W-1:0] fileWrAddr,
    input  wire logic [DATA_W-1:0]  fileWrData,
    input  wire logic               zeroWrEn,
    input  wire logic               zeroValue,
    output logic [DATA_W-1:0]       fileRdData,
    output logic [DATA_W-1:0]       accIn,
    output logic [DATA_W-1:0]       statusIn
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [DATA_W-1:0] regs_q [32];
    logic [DATA_W-1:0] acc_q;
    logic              zero_q;

    // reset contents seed the wrap and zero corners: 00, 01, FF and a spread value
    function automatic logic [DATA_W-1:0] seedVal(int i);
        logic [DATA_W-1:0] v;
        v = 8'(i) * 8'h25;
        if (i % 4 == 0) v = 8'h00;
        else if (i % 4 == 1) v = 8'h01;
        else if (i % 4 == 2) v = 8'hFF;
        return v;
    endfunction

    // writes land one cycle after the take, as the core applies them
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 32; i++) regs_q[i] <= seedVal(i);
            acc_q  <= 8'h00;
            zero_q <= 1'b0;
        end else begin
            if (fileWrEn) regs_q[fileWrAddr] <= fileWrData;
            if (accWrEn) acc_q <= accWrData;
            if (zeroWrEn) zero_q <= zeroValue;
        end
    end

    // read port follows the address of the word in the same cycle; zero flag sits at bit 2
    assign fileRdData = regs_q[rdAddr];
    assign accIn      = acc_q;
    assign statusIn   = {1'b0, pageSel, 2'b00, zero_q, 2'b00};
endmodule

`default_nettype wire

/* File: verification/incdec_skip_jump_or_exec_tb_top.sv */
// self-checking bench for the inc/dec, skip, jump and or-immediate execution block
`default_nettype none

module incdec_skip_jump_or_exec_tb_top
    import incdec_jump_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic                sys_clk = 1'b0;
    logic                reset_n = 1'b0;
    logic                instrValid = 1'b0;
    logic [INSTR_W-1:0]  instrWord = 12'h000;
    logic [PAGE_W-1:0]   pageSel = 2'h0;
    logic [DATA_W-1:0]   fileRdData, accIn, statusIn, accWrData_q, fileWrData_q;
    logic                accWrEn_q, fileWrEn_q, zeroWrEn_q, zeroValue_q, pcLoad_q;
    logic                discardFetch_q;
    logic [FADDR_W-1:0]  fileWrAddr_q;
    logic [PC_W-1:0]     pcTarget_q;
    logic                eAccEn, eFileEn, eZEn, eZ, ePcLd, eDisc, slot;
    logic [DATA_W-1:0]   eAcc, eFileD;
    logic [FADDR_W-1:0]  eAddr;
    logic [PC_W-1:0]     ePc;
    logic [5:0]          fileOpc [4] = '{OPC_DECREMENT_REGISTER, OPC_DECREMENT_SKIP_ON_ZERO,
                                         OPC_INCREMENT_REGISTER, OPC_INCREMENT_SKIP_ON_ZERO};
    logic [11:0]         corner [10] = '{12'hD00, 12'h2E1, 12'hBFF, 12'hBFF, 12'hD0F,
                                         12'h3C2, 12'h2A2, 12'h0C0, 12'h000, 12'hB23};
    logic [31:0]         r;
    int                  errorCnt = 0;
    int                  compares = 0;
    int                  seed = 19;

    always #12.5 sys_clk = ~sys_clk;

    incdec_skip_jump_exec dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
        .instrValid(instrValid), .instrWord(instrWord), .fileRdData(fileRdData),
        .accIn(accIn), .statusIn(statusIn), .accWrEn_q(accWrEn_q),
        .accWrData_q(accWrData_q), .fileWrEn_q(fileWrEn_q), .fileWrAddr_q(fileWrAddr_q),
        .fileWrData_q(fileWrData_q), .zeroWrEn_q(zeroWrEn_q), .zeroValue_q(zeroValue_q),
        .pcLoad_q(pcLoad_q), .pcTarget_q(pcTarget_q), .discardFetch_q(discardFetch_q));

    core_model model_u (.sys_clk(sys_clk), .reset_n(reset_n), .rdAddr(instrWord[4:0]),
        .pageSel(pageSel), .accWrEn(accWrEn_q), .accWrData(accWrData_q),
        .fileWrEn(fileWrEn_q), .fileWrAddr(fileWrAddr_q), .fileWrData(fileWrData_q),
        .zeroWrEn(zeroWrEn_q), .zeroValue(zeroValue_q), .fileRdData(fileRdData),
        .accIn(accIn), .statusIn(statusIn));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errorCnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stopTest();
        $display("comparisons %0d, mismatches %0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // expected outputs for the word taken at the coming edge
    function automatic void predict(logic [11:0] w, logic [7:0] rd, logic [7:0] acc,
                                    logic [7:0] st);
        logic [7:0] res;
        logic       skip;
        skip = (w[11:6] == OPC_DECREMENT_SKIP_ON_ZERO || w[11:6] == OPC_INCREMENT_SKIP_ON_ZERO);
        if (w[11:6] == OPC_DECREMENT_REGISTER || w[11:6] == OPC_DECREMENT_SKIP_ON_ZERO ||
            w[11:6] == OPC_INCREMENT_REGISTER || w[11:6] == OPC_INCREMENT_SKIP_ON_ZERO) begin
            res = (w[11:6] == OPC_INCREMENT_REGISTER ||
                   w[11:6] == OPC_INCREMENT_SKIP_ON_ZERO) ? rd + 8'h01 : rd - 8'h01;
            {eAccEn, eFileEn, eAddr, eAcc, eFileD} = {!w[5], w[5], w[4:0], res, res};
            {eZEn, eZ, eDisc} = {!skip, res == 8'h00, skip && res == 8'h00};
        end else if (w[11:9] == OPC_ABSOLUTE_JUMP) begin
            {ePcLd, ePc, eDisc} = {1'b1, st[6:5], w[8:0], 1'b1};
        end else if (w[11:8] == OPC_OR_IMMEDIATE) begin
            res = acc | w[7:0];
            {eAccEn, eAcc, eZEn, eZ} = {1'b1, res, 1'b1, res == 8'h00};
        end
    endfunction

    // compare settled outputs mid-cycle, then predict the next cycle
    always @(negedge sys_clk) begin
        if (reset_n === 1'b0) begin
            check(16'({accWrEn_q, fileWrEn_q, zeroWrEn_q, pcLoad_q, discardFetch_q}), 16'h0);
            check(16'(pcTarget_q), 16'h0000);
        end else begin
            check(16'(accWrEn_q), 16'(eAccEn));
            check(16'(fileWrEn_q), 16'(eFileEn));
            check(16'(zeroWrEn_q), 16'(eZEn));
            check(16'(pcLoad_q), 16'(ePcLd));
            check(16'(discardFetch_q), 16'(eDisc));
            if (eAccEn) check(16'(accWrData_q), 16'(eAcc));
            if (eFileEn) check({3'h0, fileWrAddr_q, fileWrData_q}, {3'h0, eAddr, eFileD});
            if (eZEn) check(16'(zeroValue_q), 16'(eZ));
            if (ePcLd) check(16'(pcTarget_q), 16'(ePc));
        end
        slot = eDisc;
        {eAccEn, eFileEn, eZEn, ePcLd, eDisc} = 5'h00;
        if (reset_n === 1'b1 && instrValid === 1'b1 && !slot)
            predict(instrWord, fileRdData, accIn, statusIn);
    end

    task automatic doReset();
        reset_n    <= 1'b0;
        instrValid <= 1'b0;
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
    endtask

    // hand-picked corners back to back, then weighted random words
    initial begin
        doReset();
        for (int k = 0; k < 10; k++) begin
            @(posedge sys_clk);
            instrValid <= 1'b1;
            instrWord  <= corner[k];
        end
        for (int n = 0; n < 3000; n++) begin
            @(posedge sys_clk);
            if (n == 1500) doReset();
            r = $random(seed);
            instrValid <= (r[30:28] != 3'h0);
            pageSel    <= r[5:4];
            case (r[2:0])
                3'h4:    instrWord <= {OPC_ABSOLUTE_JUMP, r[16:8]};
                3'h5:    instrWord <= {OPC_OR_IMMEDIATE, r[15:8]};
                3'h6:    instrWord <= r[27:16];
                default: instrWord <= {fileOpc[r[1:0]], r[13:8]};
            endcase
        end
        // let the last word be taken and its outputs compared
        repeat (2) @(posedge sys_clk);
        stopTest();
    end

    // watchdog well beyond the expected run length
    initial begin
        #200000;
        errorCnt++;
        $display("ERROR at %0t: watchdog expired", $time);
        stopTest();
    end
endmodule

`default_nettype wire
